// File: pwr_seq_pkg.sv
// package: power states, sub-modes, timing constants and carrier structs
package pwr_seq_pkg;

    typedef enum logic [4:0] {
        ST_OFF     = 5'h01,
        ST_ACTIVE  = 5'h02,
        ST_SLEEP   = 5'h04,
        ST_DORMANT = 5'h08,
        ST_BOOT    = 5'h10
    } pwr_state_t;

    typedef enum logic [1:0] {
        SUB_FULL     = 2'h0,
        SUB_IDLE     = 2'h1,
        SUB_AIRPLANE = 2'h2,
        SUB_EDRX     = 2'h3
    } sub_mode_t;

    localparam int TICK_NS = 1000;
    localparam int CLK_PERIOD_NS = 4;
    localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TIMER_W = 32;
    localparam logic [TIMER_W-1:0] WAKE_MARGIN_TICKS = 32'h0000_0010;
    localparam logic [TIMER_W-1:0] BOOT_TICKS = 32'h0000_0008;
    localparam logic [TIMER_W-1:0] TIMER_ZERO = 32'h0000_0000;
    localparam logic [TIMER_W-1:0] TIMER_ONE = 32'h0000_0001;

    typedef struct packed {
        logic usb_connected;
        logic usb_suspend;
        logic uart_dtr_idle;
        logic wake_lock_free;
        logic gpio_sleep;
        logic modem_sleep_ok;
        logic wake_trigger;
    } sleep_ctl_t;

    typedef struct packed {
        logic app_core_on;
        logic modem_on;
        logic wwan_radio_on;
        logic gnss_on;
        logic drx_on;
        logic context_kept;
        logic reachable;
        logic tau_send;
        logic emergency_off;
        logic module_reset;
    } pwr_out_t;

endpackage : pwr_seq_pkg

// File: pin_sync.sv
// two-flop synchroniser for the host control pins
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 2
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] sync;
    } sync_state_t;

    sync_state_t state_reg;
    sync_state_t state_next;

    // idle level is high: lines are active low and float high
    always_comb begin
        state_next = state_reg;
        state_next.meta = pin_in;
        state_next.sync = state_reg.meta;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            state_reg <= '{meta: '1, sync: '1};
        end else begin
            state_reg <= state_next;
        end
    end

    assign pin_out = state_reg.sync;
endmodule : pin_sync
`default_nettype wire

// File: pwr_seq.sv
// power-state sequencer: active, sleep, dormant and off
// What this block does
// - five power states (off, active, sleep, dormant, boot); functions follow state
// - active runs full, idle, airplane or edrx
// - airplane: radio off, gnss if allowed
// - sleep: core suspended, drx, watch wakes
// - sleep entry from usb, dtr, lock, gpio, modem
// - dormant keeps context, unreachable
// - dormant end: boot, then send tau
// - after tau stay active, inactivity returns dormant
// - power-up: active if on asserted else dormant
// - tau timer sets dormant length only
// - wakeup timer slightly shorter than tau
// - reset with on asserted resets, wakes
// - reset with on off: emergency off
// - wake on power-on line falling edge
`timescale 1ns/10ps
`default_nettype none
module pwr_seq
    import pwr_seq_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic supply_ok,
    input wire logic power_on_n,
    input wire logic reset_in_n,
    input wire sub_mode_t sub_mode_req,
    input wire logic gnss_allowed,
    input wire logic psm_enable,
    input wire logic [TIMER_W-1:0] tau_ticks,
    input wire logic [TIMER_W-1:0] inact_ticks,
    input wire logic data_activity,
    input wire sleep_ctl_t sleep_ctl,
    output pwr_state_t pwr_state,
    output sub_mode_t sub_mode,
    output pwr_out_t pwr_out
);
    typedef struct packed {
        pwr_state_t st;
        sub_mode_t sub;
        logic [15:0] tick_cnt;
        logic [TIMER_W-1:0] timer;
        logic on_prev;
        logic rst_prev;
        logic tau_pend;
        logic hold_off;
        pwr_out_t out;
    } seq_state_t;

    seq_state_t s_reg;
    seq_state_t s_next;
    logic [1:0] pins_sync;
    logic on_req;
    logic rst_req;
    logic tick;
    logic sleep_ok;
    logic [TIMER_W-1:0] wake_ticks;

    // both host lines cross into core_clk before use
    pin_sync #(.WIDTH(2)) u_sync (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .pin_in({power_on_n, reset_in_n}),
        .pin_out(pins_sync)
    );

    assign on_req = ~pins_sync[1];
    assign rst_req = ~pins_sync[0];
    assign tick = (s_reg.tick_cnt == 16'(TICK_LEN - 1));

    // wake early so boot ends before the network expects the update
    assign wake_ticks = (tau_ticks > WAKE_MARGIN_TICKS) ? tau_ticks - WAKE_MARGIN_TICKS
                                                       : TIMER_ONE;

    assign sleep_ok = ((sleep_ctl.usb_connected & sleep_ctl.usb_suspend)
                      | sleep_ctl.uart_dtr_idle | sleep_ctl.wake_lock_free
                      | sleep_ctl.gpio_sleep | sleep_ctl.modem_sleep_ok);

    always_comb begin
        s_next = s_reg;
        s_next.on_prev = on_req;
        s_next.rst_prev = rst_req;
        s_next.tick_cnt = tick ? 16'h0000 : s_reg.tick_cnt + 16'h0001;
        if (tick && s_reg.timer != TIMER_ZERO) begin
            s_next.timer = s_reg.timer - TIMER_ONE;
        end
        s_next.out.tau_send = 1'b0;
        s_next.out.module_reset = 1'b0;
        s_next.out.emergency_off = 1'b0;
        case (s_reg.st)
            ST_OFF: begin
                if (supply_ok && !s_reg.hold_off) begin
                    if (on_req) begin
                        s_next.st = ST_ACTIVE;
                    end else begin
                        s_next.st = ST_DORMANT;
                        s_next.timer = wake_ticks;
                    end
                end
            end
            ST_ACTIVE: begin
                s_next.sub = sub_mode_req;
                if (s_reg.tau_pend) begin
                    s_next.out.tau_send = 1'b1;
                    s_next.tau_pend = 1'b0;
                    s_next.timer = inact_ticks;
                end else if (data_activity) begin
                    s_next.timer = inact_ticks;
                end else if (psm_enable && s_reg.timer == TIMER_ZERO) begin
                    s_next.st = ST_DORMANT;
                    s_next.timer = wake_ticks;
                end else if (!psm_enable && sleep_ok) begin
                    s_next.st = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (sleep_ctl.wake_trigger || !sleep_ok) begin
                    s_next.st = ST_ACTIVE;
                end
            end
            ST_DORMANT: begin
                if (tick && s_reg.timer == TIMER_ONE) begin
                    s_next.st = ST_BOOT;
                    s_next.timer = BOOT_TICKS;
                end else if (on_req && !s_reg.on_prev) begin
                    s_next.st = ST_BOOT;
                    s_next.timer = BOOT_TICKS;
                end
            end
            ST_BOOT: begin
                if (s_reg.timer == TIMER_ZERO) begin
                    s_next.st = ST_ACTIVE;
                    s_next.tau_pend = 1'b1;
                end
            end
            default: s_next.st = ST_OFF;
        endcase
        // reset line wins over every state except off
        if (s_reg.st != ST_OFF && rst_req && !s_reg.rst_prev) begin
            if (on_req) begin
                s_next.out.module_reset = 1'b1;
                s_next.st = ST_BOOT;
                s_next.timer = BOOT_TICKS;
            end else begin
                s_next.out.emergency_off = 1'b1;
                s_next.hold_off = 1'b1;
                s_next.st = ST_OFF;
                s_next.timer = TIMER_ZERO;
            end
        end
        // emergency off holds until the supply is removed, so it cannot bounce to dormant
        if (!supply_ok) begin
            s_next.st = ST_OFF;
            s_next.hold_off = 1'b0;
        end
        // function enables follow the next state
        s_next.out.app_core_on = (s_next.st == ST_ACTIVE) || (s_next.st == ST_BOOT);
        s_next.out.modem_on = (s_next.st == ST_ACTIVE) || (s_next.st == ST_BOOT)
                              || (s_next.st == ST_SLEEP);
        s_next.out.drx_on = (s_next.st == ST_SLEEP)
                            || (s_next.st == ST_ACTIVE && s_next.sub == SUB_EDRX);
        s_next.out.wwan_radio_on = (s_next.st == ST_ACTIVE && s_next.sub != SUB_AIRPLANE)
                                   || (s_next.st == ST_SLEEP);
        s_next.out.gnss_on = (s_next.st == ST_ACTIVE) && gnss_allowed;
        s_next.out.context_kept = (s_next.st != ST_OFF);
        s_next.out.reachable = (s_next.st == ST_ACTIVE) || (s_next.st == ST_SLEEP);
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            s_reg <= '{st: ST_OFF, sub: SUB_FULL, tick_cnt: 16'h0000, timer: TIMER_ZERO,
                       on_prev: 1'b0, rst_prev: 1'b0, tau_pend: 1'b0, hold_off: 1'b0, out: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign pwr_state = s_reg.st;
    assign sub_mode = s_reg.sub;
    assign pwr_out = s_reg.out;

    a_dormant_dark: assert property (@(posedge core_clk) disable iff (sys_rst)
        (pwr_state == ST_DORMANT) |-> (!pwr_out.reachable && pwr_out.context_kept
        && !pwr_out.app_core_on)) else $error("dormant state not dark");
    a_airplane_radio: assert property (@(posedge core_clk) disable iff (sys_rst)
        (pwr_state == ST_ACTIVE && sub_mode == SUB_AIRPLANE) |-> !pwr_out.wwan_radio_on)
        else $error("radio on in airplane");
    a_sleep_core: assert property (@(posedge core_clk) disable iff (sys_rst)
        (pwr_state == ST_SLEEP) |-> (!pwr_out.app_core_on && pwr_out.drx_on))
        else $error("sleep left core running");
    a_boot_then_tau: assert property (@(posedge core_clk) disable iff (sys_rst)
        ($past(pwr_state) == ST_BOOT && pwr_state == ST_ACTIVE && supply_ok) |=> pwr_out.tau_send
        or (pwr_state != ST_ACTIVE)) else $error("no update after boot");
    a_power_up_on: assert property (@(posedge core_clk) disable iff (sys_rst)
        (pwr_state == ST_OFF && supply_ok && !s_reg.hold_off && on_req && !rst_req)
        |=> pwr_state == ST_ACTIVE) else $error("power up not active");
    a_power_up_off: assert property (@(posedge core_clk) disable iff (sys_rst)
        (pwr_state == ST_OFF && supply_ok && !s_reg.hold_off && !on_req)
        |=> pwr_state == ST_DORMANT) else $error("power up not dormant");
    a_reset_wake: assert property (@(posedge core_clk) disable iff (sys_rst)
        (pwr_state != ST_OFF && supply_ok && rst_req && !s_reg.rst_prev && on_req)
        |=> (pwr_out.module_reset && pwr_state == ST_BOOT)) else $error("reset not taken");
    a_emerg_off: assert property (@(posedge core_clk) disable iff (sys_rst)
        (pwr_state != ST_OFF && rst_req && !s_reg.rst_prev && !on_req)
        |=> (pwr_out.emergency_off && pwr_state == ST_OFF)) else $error("no emergency off");
    a_off_holds: assert property (@(posedge core_clk) disable iff (sys_rst)
        (pwr_state == ST_OFF && s_reg.hold_off && supply_ok) |=> pwr_state == ST_OFF)
        else $error("emergency off did not hold");
    a_off_dark: assert property (@(posedge core_clk) disable iff (sys_rst)
        (pwr_state == ST_OFF) |-> (!pwr_out.app_core_on && !pwr_out.modem_on
        && !pwr_out.wwan_radio_on && !pwr_out.context_kept)) else $error("off state not dark");
    a_edrx_drx: assert property (@(posedge core_clk) disable iff (sys_rst)
        (pwr_state == ST_ACTIVE && sub_mode == SUB_EDRX) |-> pwr_out.drx_on)
        else $error("edrx without drx");
    a_on_wake: assert property (@(posedge core_clk) disable iff (sys_rst)
        (pwr_state == ST_DORMANT && supply_ok && on_req && !s_reg.on_prev && !rst_req)
        |=> pwr_state == ST_BOOT) else $error("power-on edge did not wake");
    a_wake_short: assert property (@(posedge core_clk) disable iff (sys_rst)
        (tau_ticks > WAKE_MARGIN_TICKS) |-> (wake_ticks < tau_ticks))
        else $error("wakeup timer not shorter");
endmodule : pwr_seq
`default_nettype wire

// File: host_model.sv
// host side model: drives the power-on and reset request pins
`timescale 1ns/10ps
`default_nettype none
module host_model (
    input wire logic on_req,
    input wire logic rst_req,
    output logic power_on_n,
    output logic reset_in_n
);
    // released lines sit at the pull-up level, never at a stale low
    assign power_on_n = on_req ? 1'b0 : 1'b1;
    assign reset_in_n = rst_req ? 1'b0 : 1'b1;
endmodule : host_model
`default_nettype wire

// File: tb_pwr_seq.sv
// testbench for the power-state sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin err_total++; \
    $display("[ERR] %s exp=%0h got=%0h", what, exp, got); end end
module tb_pwr_seq;
    import pwr_seq_pkg::*;
    localparam int TL = 2;
    logic core_clk, sys_rst, supply_ok, on_req, rst_req, power_on_n, reset_in_n;
    logic gnss_allowed, psm_enable, data_activity;
    logic seen_tau, seen_rst, seen_eoff, seen_boot;
    sub_mode_t sub_mode_req, sub_mode;
    logic [TIMER_W-1:0] tau_ticks, inact_ticks;
    sleep_ctl_t sleep_ctl;
    pwr_state_t pwr_state;
    pwr_out_t pwr_out;
    int err_total = 0;
    int check_count = 0;
    int n;

    host_model u_host_model (.on_req(on_req), .rst_req(rst_req),
        .power_on_n(power_on_n), .reset_in_n(reset_in_n));
    pwr_seq #(.TICK_LEN(TL)) u_pwr_seq (.core_clk(core_clk), .sys_rst(sys_rst),
        .supply_ok(supply_ok), .power_on_n(power_on_n), .reset_in_n(reset_in_n),
        .sub_mode_req(sub_mode_req), .gnss_allowed(gnss_allowed), .psm_enable(psm_enable),
        .tau_ticks(tau_ticks), .inact_ticks(inact_ticks), .data_activity(data_activity),
        .sleep_ctl(sleep_ctl), .pwr_state(pwr_state), .sub_mode(sub_mode), .pwr_out(pwr_out));

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    // sticky flags, because pulses last one cycle and the waits poll
    always @(posedge core_clk) begin
        if (pwr_out.tau_send === 1'b1) seen_tau = 1'b1;
        if (pwr_out.module_reset === 1'b1) seen_rst = 1'b1;
        if (pwr_out.emergency_off === 1'b1) seen_eoff = 1'b1;
        if (pwr_state === ST_BOOT) seen_boot = 1'b1;
    end

    task automatic step(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask : step

    task automatic wait_st(input pwr_state_t s, input int lim);
        n = 0;
        while (pwr_state !== s && n < lim) begin
            step(1);
            n++;
        end
    endtask : wait_st

    task automatic clr_flags;
        {seen_tau, seen_rst, seen_eoff, seen_boot} = 4'h0;
    endtask : clr_flags

    task automatic power_up(input logic on);
        supply_ok = 1'b0;
        on_req = on;
        step(4);
        supply_ok = 1'b1;
    endtask : power_up

    task automatic t_active_modes;
        power_up(1'b1);
        wait_st(ST_ACTIVE, 10);
        `CHK("up on", ST_ACTIVE, pwr_state)
        `CHK("core on", 1'b1, pwr_out.app_core_on)
        for (int m = 0; m < 4; m++) begin
            sub_mode_req = sub_mode_t'(m);
            gnss_allowed = (m >= 2);
            step(3);
            `CHK("sub", sub_mode_t'(m), sub_mode)
            `CHK("radio", (m != 2), pwr_out.wwan_radio_on)
            `CHK("gnss", (m >= 2), pwr_out.gnss_on)
            `CHK("edrx", (m == 3), pwr_out.drx_on)
        end
        sub_mode_req = SUB_FULL;
    endtask : t_active_modes

    task automatic t_sleep;
        sleep_ctl.usb_suspend = 1'b1;
        step(10);
        `CHK("usb detached", ST_ACTIVE, pwr_state)
        // each entry source alone: usb suspend, wake lock, gpio, modem messaging
        for (int k = 0; k < 4; k++) begin
            sleep_ctl = sleep_ctl_t'((k == 0) ? 7'h60 : (7'h08 >> (k - 1)));
            wait_st(ST_SLEEP, 10);
            `CHK("sleep src", ST_SLEEP, pwr_state)
            sleep_ctl = '0;
            wait_st(ST_ACTIVE, 10);
            `CHK("src gone", ST_ACTIVE, pwr_state)
        end
        sleep_ctl = '0;
        sleep_ctl.uart_dtr_idle = 1'b1;
        wait_st(ST_SLEEP, 10);
        `CHK("sleep", ST_SLEEP, pwr_state)
        `CHK("core off", 1'b0, pwr_out.app_core_on)
        `CHK("drx", 1'b1, pwr_out.drx_on)
        `CHK("modem", 1'b1, pwr_out.modem_on)
        sleep_ctl.wake_trigger = 1'b1;
        wait_st(ST_ACTIVE, 10);
        `CHK("wake", ST_ACTIVE, pwr_state)
        sleep_ctl = '0;
    endtask : t_sleep

    task automatic t_psm_cycle;
        power_up(1'b0);
        wait_st(ST_DORMANT, 10);
        `CHK("up off", ST_DORMANT, pwr_state)
        `CHK("ctx", 1'b1, pwr_out.context_kept)
        `CHK("unreach", 1'b0, pwr_out.reachable)
        `CHK("modem off", 1'b0, pwr_out.modem_on)
        clr_flags();
        wait_st(ST_ACTIVE, 60);
        `CHK("timer wake", ST_ACTIVE, pwr_state)
        `CHK("booted", 1'b1, seen_boot)
        // wake must land before the full period runs out
        `CHK("early", 1'b1, n >= 4 * TL && n < 20 * TL)
        step(2);
        `CHK("tau", 1'b1, seen_tau)
        tau_ticks = 32'h0000_03e8;
        psm_enable = 1'b1;
        data_activity = 1'b1;
        step(20);
        `CHK("traffic holds", ST_ACTIVE, pwr_state)
        data_activity = 1'b0;
        wait_st(ST_DORMANT, 40);
        `CHK("redormant", ST_DORMANT, pwr_state)
    endtask : t_psm_cycle

    task automatic t_pins;
        step(20);
        `CHK("stay", ST_DORMANT, pwr_state)
        on_req = 1'b1;
        wait_st(ST_ACTIVE, 40);
        `CHK("pin wake", ST_ACTIVE, pwr_state)
        psm_enable = 1'b0;
        clr_flags();
        rst_req = 1'b1;
        step(4);
        rst_req = 1'b0;
        `CHK("reset", 1'b1, seen_rst)
        `CHK("boot", 1'b1, seen_boot)
        wait_st(ST_ACTIVE, 40);
        on_req = 1'b0;
        clr_flags();
        step(2);
        rst_req = 1'b1;
        step(6);
        `CHK("eoff", 1'b1, seen_eoff)
        `CHK("no reset", 1'b0, seen_rst)
        `CHK("stay off", ST_OFF, pwr_state)
        rst_req = 1'b0;
    endtask : t_pins

    // mid-run reset: all dark, then power-up from off again
    task automatic t_reset;
        sys_rst = 1'b1;
        step(3);
        `CHK("rst state", ST_OFF, pwr_state)
        `CHK("rst outs", 10'h000, pwr_out)
        sys_rst = 1'b0;
        step(2);
        `CHK("rst then up", ST_DORMANT, pwr_state)
    endtask : t_reset

    task automatic final_report;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    initial begin
        {sys_rst, supply_ok, on_req, rst_req} = 4'h8;
        {gnss_allowed, psm_enable, data_activity} = 3'h0;
        sub_mode_req = SUB_FULL;
        tau_ticks = 32'h0000_0014;
        inact_ticks = 32'h0000_0004;
        sleep_ctl = '0;
        clr_flags();
        step(5);
        sys_rst = 1'b0;
        step(2);
        t_active_modes();
        t_sleep();
        t_psm_cycle();
        t_pins();
        t_reset();
        final_report();
    end

    initial begin
        #80000;
        err_total++;
        final_report();
    end
endmodule : tb_pwr_seq
`default_nettype wire
